// *** logic/mstm_pkg.sv ***
// Purpose: Shared constants and types of the measurement statistics and record memory block
// Assumes: APB word registers, 100 MHz core clock
// Notes:   Quantity q=0 is resistance, q=1 is voltage
package mstm_pkg;
   // Clock and self-calibration timing
   localparam longint unsigned CLK_NS      = 10;
   localparam longint unsigned CAL_MIN     = 30;
   localparam longint unsigned CAL_CYCLES  = CAL_MIN * 60 * 1000000000 / CLK_NS;
   // Sizes and limits
   localparam int              SW          = 20;
   localparam int              CW          = 15;
   localparam logic [14:0]     CNT_MAX     = 15'h7530;
   localparam logic [8:0]      MEM_DEPTH   = 9'h190;
   localparam logic [15:0]     CP_MAX      = 16'h270F;
   // Register offsets, global page
   localparam logic [7:0]      A_CTRL      = 8'h00;
   localparam logic [7:0]      A_CMD       = 8'h04;
   localparam logic [7:0]      A_MCOUNT    = 8'h08;
   localparam logic [7:0]      A_REC_IDX   = 8'h0C;
   localparam logic [7:0]      A_REC_RES   = 8'h10;
   localparam logic [7:0]      A_REC_VOLT  = 8'h14;
   // Per-quantity page base in paddr[7:6], offsets in paddr[5:0]
   localparam logic [1:0]      PG_RES      = 2'h1;
   localparam logic [1:0]      PG_VOLT     = 2'h2;
   localparam logic [5:0]      Q_CNT       = 6'h00;
   localparam logic [5:0]      Q_SUM       = 6'h04;
   localparam logic [5:0]      Q_MAX       = 6'h08;
   localparam logic [5:0]      Q_MAXNO     = 6'h0C;
   localparam logic [5:0]      Q_MIN       = 6'h10;
   localparam logic [5:0]      Q_MINNO     = 6'h14;
   localparam logic [5:0]      Q_TAL01     = 6'h18;
   localparam logic [5:0]      Q_TAL23     = 6'h1C;
   localparam logic [5:0]      Q_SIG       = 6'h20;
   localparam logic [5:0]      Q_CP        = 6'h24;
   // CTRL and CMD bit positions
   localparam int              C_STAT_EN   = 0;
   localparam int              C_MEM_EN    = 1;
   localparam int              C_STEP      = 2;
   localparam int              C_AUTOCAL   = 3;
   localparam int              C_AUTOOUT   = 4;
   localparam int              C_GPIB      = 5;
   localparam int              K_STAT_CLR  = 0;
   localparam int              K_MEM_CLR   = 1;
   localparam int              K_TRG       = 2;
   localparam int              K_DL_START  = 3;
   localparam int              K_NEXT      = 4;
   localparam int              K_CAL       = 5;
   localparam logic [5:0]      CTRL_RST    = 6'h00;

   typedef enum logic [1:0] {
      J_IN = 2'b00,
      J_HI = 2'b01,
      J_LO = 2'b10
   } mstm_judge_t;

   typedef enum logic [1:0] {
      DL_IDLE = 2'b00,
      DL_BULK = 2'b01,
      DL_STEP = 2'b10,
      DL_END  = 2'b11
   } mstm_dl_t;

   typedef struct packed {
      logic signed [SW-1:0] value;
      logic                 fault;
      logic                 ovf;
      mstm_judge_t          judge;
   } mstm_samp_t;

   typedef struct packed {
      logic signed [SW-1:0] res;
      logic signed [SW-1:0] volt;
   } mstm_pair_t;
endpackage

// *** logic/mstm_top.sv ***
// Purpose: Statistics on triggered readings and a 400-record memory behind APB
// Assumes: Readings come from same-clock logic; trigger pins are asynchronous
// Notes:   Sigma and capability values are computed by firmware and written back
//
// How it works
// - Every trigger source takes one statistics sample
// - Statistics on/off keeps accumulated results
// - Sigma n-1 reads zero with no valid samples
// - Clear keeps statistics function enabled
// - Capability indices clamp at 99.99
// - Negative capability indices read as 0.00
// - Clear command wipes both quantities
// - Total and valid counts, 0 to 30000
// - Fault and overflow samples excluded from statistics
// - Mean available from sum and valid count
// - Maximum with its sample number
// - Minimum with its sample number
// - Four outcome tallies: above, within, below, fault
// - Record count query, 0 to 400
// - Triggers append records while memory enabled
// - Full memory discards further readings
// - Memory enabled forces auto-range off
// - Bulk download or one record per next request
// - Record starts with index; end marker follows
// - Each record carries a terminator
// - Auto self-calibration every 30 minutes
// - Auto result output, not on GP-IB
// - Comparator change erases record memory
`timescale 1ns/1ns
module mstm_top #(
   parameter logic [37:0] CAL_CYCLES = 38'(mstm_pkg::CAL_CYCLES)
) (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata_q,
   output logic                    pready_q,
   output logic                    pslverr_q,
   input  wire logic               trig_key_pin,
   input  wire logic               external_control_port_trig,
   input  wire mstm_pkg::mstm_samp_t meas_res,
   input  wire mstm_pkg::mstm_samp_t meas_volt,
   input  wire logic               cmp_cfg_change,
   output logic                    auto_range_off_q,
   output logic                    cal_req_q,
   output logic                    out_valid_q,
   output mstm_pkg::mstm_pair_t    out_data_q
);
   // Two-flop synchronisers, third stage for edge detect
   logic [2:0] key_s_q;
   logic [2:0] ext_s_q;
   always_ff @(posedge core_clk) begin
      key_s_q <= rst ? 3'h0 : {key_s_q[1:0], trig_key_pin};
      ext_s_q <= rst ? 3'h0 : {ext_s_q[1:0], external_control_port_trig};
   end

   // APB decode
   logic [5:0]  ctrl_q;
   logic        acc, wr, rd, setup;
   logic [1:0]  pg;
   logic [5:0]  qoff;
   assign setup = psel && !penable;
   assign acc   = psel && penable && pready_q;
   assign wr    = acc && pwrite;
   assign rd    = acc && !pwrite;
   assign pg    = paddr[7:6];
   assign qoff  = paddr[5:0];

   // Command pulses, valid only at the completing edge
   logic wr_cmd, stat_clr, mem_clr, cmd_trg, dl_start, dl_next, cmd_cal;
   assign wr_cmd   = wr && paddr == mstm_pkg::A_CMD;
   assign stat_clr = wr_cmd && pwdata[mstm_pkg::K_STAT_CLR];
   assign mem_clr  = wr_cmd && pwdata[mstm_pkg::K_MEM_CLR];
   assign cmd_trg  = wr_cmd && pwdata[mstm_pkg::K_TRG];
   assign dl_start = wr_cmd && pwdata[mstm_pkg::K_DL_START];
   assign dl_next  = wr_cmd && pwdata[mstm_pkg::K_NEXT];
   assign cmd_cal  = wr_cmd && pwdata[mstm_pkg::K_CAL];

   // Key, port and bus triggers are one event
   logic trig;
   assign trig = (key_s_q[1] && !key_s_q[2]) || (ext_s_q[1] && !ext_s_q[2]) || cmd_trg;

   // Control register; writing it never touches accumulated results
   always_ff @(posedge core_clk) begin
      if (rst)
         ctrl_q <= mstm_pkg::CTRL_RST;
      else if (wr && paddr == mstm_pkg::A_CTRL)
         ctrl_q <= pwdata[5:0];
   end

   logic take;
   assign take = trig && ctrl_q[mstm_pkg::C_STAT_EN];

   // Clamp of a signed x100 capability value into 0..99.99
   function automatic logic [15:0] clamp_cp(input logic signed [15:0] v);
      if (v < 0)
         return 16'h0000;
      else if (v > $signed(mstm_pkg::CP_MAX))
         return mstm_pkg::CP_MAX;
      else
         return v;
   endfunction

   mstm_pkg::mstm_samp_t samp [2];
   logic [31:0]          q_rd [2];
   logic [14:0]          q_valid [2];
   assign samp[0] = meas_res;
   assign samp[1] = meas_volt;

   // One accumulator set per quantity, fed only by its own readings
   for (genvar q = 0; q < 2; q++) begin : st
      logic [14:0]             total_q, valid_q, maxno_q, minno_q, seq;
      logic [14:0]             tal_q [4];
      logic [31:0]             sum_q, sig_q, cp_q;
      logic signed [19:0]      max_q, min_q, v;
      logic                    ok, wsel;
      assign v    = samp[q].value;
      assign ok   = !samp[q].fault && !samp[q].ovf;
      assign seq  = total_q + 15'h0001;
      assign wsel = wr && pg == (q == 0 ? mstm_pkg::PG_RES : mstm_pkg::PG_VOLT);
      assign q_valid[q] = valid_q;

      // Accumulate; clear wipes both quantities, enable bit untouched
      always_ff @(posedge core_clk) begin
         if (rst || stat_clr) begin
            total_q <= 15'h0000;
            valid_q <= 15'h0000;
            sum_q   <= 32'h0000_0000;
            max_q   <= 20'sh0_0000;
            min_q   <= 20'sh0_0000;
            maxno_q <= 15'h0000;
            minno_q <= 15'h0000;
            for (int i = 0; i < 4; i++)
               tal_q[i] <= 15'h0000;
         end else if (take && total_q < mstm_pkg::CNT_MAX) begin
            total_q <= seq;
            if (samp[q].fault)
               tal_q[3] <= tal_q[3] + 15'h0001;
            else if (samp[q].judge == mstm_pkg::J_HI)
               tal_q[0] <= tal_q[0] + 15'h0001;
            else if (samp[q].judge == mstm_pkg::J_IN)
               tal_q[1] <= tal_q[1] + 15'h0001;
            else if (samp[q].judge == mstm_pkg::J_LO)
               tal_q[2] <= tal_q[2] + 15'h0001;
            if (ok) begin
               valid_q <= valid_q + 15'h0001;
               sum_q   <= sum_q + {{12{v[19]}}, v};
               if (valid_q == 15'h0000 || v > max_q) begin
                  max_q   <= v;
                  maxno_q <= seq;
               end
               if (valid_q == 15'h0000 || v < min_q) begin
                  min_q   <= v;
                  minno_q <= seq;
               end
            end
         end
      end

      // Firmware-computed sigma n-1 and capability pair
      always_ff @(posedge core_clk) begin
         if (rst) begin
            sig_q <= 32'h0000_0000;
            cp_q  <= 32'h0000_0000;
         end else begin
            if (wsel && qoff == mstm_pkg::Q_SIG)
               sig_q <= pwdata;
            if (wsel && qoff == mstm_pkg::Q_CP)
               cp_q <= pwdata;
         end
      end

      // Read mux of this quantity's page
      always_comb begin
         unique case (qoff)
            mstm_pkg::Q_CNT:   q_rd[q] = {1'b0, valid_q, 1'b0, total_q};
            mstm_pkg::Q_SUM:   q_rd[q] = sum_q;
            mstm_pkg::Q_MAX:   q_rd[q] = {{12{max_q[19]}}, max_q};
            mstm_pkg::Q_MAXNO: q_rd[q] = {17'h0_0000, maxno_q};
            mstm_pkg::Q_MIN:   q_rd[q] = {{12{min_q[19]}}, min_q};
            mstm_pkg::Q_MINNO: q_rd[q] = {17'h0_0000, minno_q};
            mstm_pkg::Q_TAL01: q_rd[q] = {1'b0, tal_q[1], 1'b0, tal_q[0]};
            mstm_pkg::Q_TAL23: q_rd[q] = {1'b0, tal_q[3], 1'b0, tal_q[2]};
            mstm_pkg::Q_SIG:   q_rd[q] = valid_q == 15'h0000 ? 32'h0000_0000 : sig_q;
            mstm_pkg::Q_CP:    q_rd[q] = {clamp_cp(cp_q[31:16]), clamp_cp(cp_q[15:0])};
            default:           q_rd[q] = 32'h0000_0000;
         endcase
      end
   end

   // Record memory: flops addressed by index, no reset on data
   mstm_pkg::mstm_pair_t mem_q [mstm_pkg::MEM_DEPTH];
   logic [8:0]           mcnt_q, rptr_q, rnext;
   mstm_pkg::mstm_dl_t   dl_q;
   logic                 full, erase, store, adv;
   assign full  = mcnt_q == mstm_pkg::MEM_DEPTH;
   assign erase = mem_clr || cmp_cfg_change;
   assign store = trig && ctrl_q[mstm_pkg::C_MEM_EN] && !full;
   assign rnext = rptr_q + 9'h001;
   assign adv   = (dl_q == mstm_pkg::DL_BULK && rd && paddr == mstm_pkg::A_REC_VOLT)
               || (dl_q == mstm_pkg::DL_STEP && dl_next);

   always_ff @(posedge core_clk) begin
      if (store)
         mem_q[mcnt_q] <= '{res: meas_res.value, volt: meas_volt.value};
   end

   // Record count
   always_ff @(posedge core_clk) begin
      if (rst || erase)
         mcnt_q <= 9'h000;
      else if (store)
         mcnt_q <= mcnt_q + 9'h001;
   end

   // Download walker; bulk advances on each voltage read, step on next request
   always_ff @(posedge core_clk) begin
      if (rst || erase) begin
         dl_q   <= mstm_pkg::DL_IDLE;
         rptr_q <= 9'h000;
      end else if (dl_start) begin
         rptr_q <= 9'h000;
         if (mcnt_q == 9'h000)
            dl_q <= mstm_pkg::DL_END;
         else if (ctrl_q[mstm_pkg::C_STEP])
            dl_q <= mstm_pkg::DL_STEP;
         else
            dl_q <= mstm_pkg::DL_BULK;
      end else if (adv) begin
         rptr_q <= rnext;
         if (rnext >= mcnt_q)
            dl_q <= mstm_pkg::DL_END;
      end
   end

   // Record words; bit 31 flags a terminated record, bit 30 the end marker
   logic        rec_on;
   logic [31:0] rec_idx, rec_res, rec_volt;
   assign rec_on   = dl_q == mstm_pkg::DL_BULK || dl_q == mstm_pkg::DL_STEP;
   assign rec_idx  = {rec_on, dl_q == mstm_pkg::DL_END, 21'h00_0000,
                      rec_on ? rnext : 9'h000};
   assign rec_res  = rec_on ? {{12{mem_q[rptr_q].res[19]}}, mem_q[rptr_q].res} : 32'h0000_0000;
   assign rec_volt = rec_on ? {{12{mem_q[rptr_q].volt[19]}}, mem_q[rptr_q].volt} : 32'h0000_0000;

   // Global read mux and unmapped detect
   logic [31:0] rd_d;
   logic        bad_d;
   always_comb begin
      bad_d = 1'b0;
      if (pg == mstm_pkg::PG_RES)
         rd_d = q_rd[0];
      else if (pg == mstm_pkg::PG_VOLT)
         rd_d = q_rd[1];
      else begin
         unique case (paddr)
            mstm_pkg::A_CTRL:     rd_d = {26'h000_0000, ctrl_q};
            mstm_pkg::A_CMD:      rd_d = 32'h0000_0000;
            mstm_pkg::A_MCOUNT:   rd_d = {23'h00_0000, mcnt_q};
            mstm_pkg::A_REC_IDX:  rd_d = rec_idx;
            mstm_pkg::A_REC_RES:  rd_d = rec_res;
            mstm_pkg::A_REC_VOLT: rd_d = rec_volt;
            default: begin
               rd_d  = 32'h0000_0000;
               bad_d = 1'b1;
            end
         endcase
      end
   end

   // APB answer: data latched in setup, ready in the first access cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && bad_d;
         if (setup)
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
   end

   // Auto-range override, self-calibration timer, unprompted result output
   logic [37:0] cal_cnt_q;
   logic        cal_hit, auto_out;
   assign cal_hit  = cal_cnt_q == CAL_CYCLES - 38'h1;
   assign auto_out = ctrl_q[mstm_pkg::C_AUTOOUT] && !ctrl_q[mstm_pkg::C_GPIB];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         auto_range_off_q <= 1'b0;
         cal_cnt_q        <= 38'h0;
         cal_req_q        <= 1'b0;
         out_valid_q      <= 1'b0;
         out_data_q       <= '0;
      end else begin
         auto_range_off_q <= ctrl_q[mstm_pkg::C_MEM_EN];
         if (!ctrl_q[mstm_pkg::C_AUTOCAL] || cal_hit)
            cal_cnt_q <= 38'h0;
         else
            cal_cnt_q <= cal_cnt_q + 38'h1;
         cal_req_q   <= cmd_cal || (ctrl_q[mstm_pkg::C_AUTOCAL] && cal_hit);
         out_valid_q <= trig && auto_out;
         if (trig && auto_out)
            out_data_q <= '{res: meas_res.value, volt: meas_volt.value};
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_trig_count;
      take && !stat_clr && st[0].total_q < mstm_pkg::CNT_MAX
         |=> st[0].total_q == $past(st[0].total_q) + 15'h0001;
   endproperty
   a_trig_count: assert property (p_trig_count) else $error("trigger not counted");

   property p_en_keeps;
      wr && paddr == mstm_pkg::A_CTRL && !take && !stat_clr |=> $stable(st[0].valid_q);
   endproperty
   a_en_keeps: assert property (p_en_keeps) else $error("enable change hit results");

   property p_sig_zero;
      q_valid[0] == 15'h0000 && pg == mstm_pkg::PG_RES && qoff == mstm_pkg::Q_SIG
         |-> rd_d == 32'h0000_0000;
   endproperty
   a_sig_zero: assert property (p_sig_zero) else $error("sigma nonzero at zero count");

   sequence s_clear;
      stat_clr ##1 1'b1;
   endsequence
   property p_clear;
      s_clear |-> st[0].total_q == 15'h0000 && st[1].total_q == 15'h0000
         && ctrl_q == $past(ctrl_q);
   endproperty
   a_clear: assert property (p_clear) else $error("clear incomplete");

   property p_cp_clamp;
      $signed(st[0].cp_q[15:0]) > $signed(mstm_pkg::CP_MAX)
         && pg == mstm_pkg::PG_RES && qoff == mstm_pkg::Q_CP
         |-> rd_d[15:0] == mstm_pkg::CP_MAX;
   endproperty
   a_cp_clamp: assert property (p_cp_clamp) else $error("cp above bound");

   property p_fault_skip;
      take && !stat_clr && !st[0].ok |=> $stable(st[0].valid_q) && $stable(st[0].sum_q);
   endproperty
   a_fault_skip: assert property (p_fault_skip) else $error("bad sample counted");

   property p_full_hold;
      full && !erase |=> mcnt_q == mstm_pkg::MEM_DEPTH;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full memory grew");

   property p_range_off;
      ctrl_q[mstm_pkg::C_MEM_EN] [*2] |-> auto_range_off_q;
   endproperty
   a_range_off: assert property (p_range_off) else $error("auto-range left on");

   property p_erase;
      cmp_cfg_change |=> mcnt_q == 9'h000 && dl_q == mstm_pkg::DL_IDLE;
   endproperty
   a_erase: assert property (p_erase) else $error("memory not erased");
endmodule // mstm_top

// *** sim/mstm_host.sv ***
// Purpose: Host model that reaches the block over APB
// Assumes: Host waits at most 20 cycles for pready_q
// Notes:   A wait that runs out is counted in to_cnt
`timescale 1ns/1ns
module mstm_host (
   input  wire logic        core_clk,
   output logic             psel     = 1'b0,
   output logic             penable  = 1'b0,
   output logic             pwrite   = 1'b0,
   output logic [7:0]       paddr    = 8'h00,
   output logic [31:0]      pwdata   = 32'h0000_0000,
   input  wire logic [31:0] prdata_q,
   input  wire logic        pready_q,
   input  wire logic        pslverr_q
);
   int to_cnt = 0;

   // Setup, then access held until pready_q is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      rd = 32'h0000_0000;
      err = 1'b1;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Sample at the rising edge, before that edge's own updates land
      do begin
         @(posedge core_clk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      if (pready_q === 1'b1) begin
         rd = prdata_q;
         err = pslverr_q;
      end else begin
         to_cnt++;
      end
      // Released right after the completing edge
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Next-record request; a complete transfer is the terminated request
   task automatic next_rec();
      logic [31:0] r;
      logic        e;
      xfer(1'b1, mstm_pkg::A_CMD, 32'h0000_0010, r, e);
   endtask
endmodule // mstm_host

// *** sim/testbench.sv ***
// Purpose: Self-checking bench of statistics and record memory
// Assumes: Calibration interval shortened to 50 cycles
// Notes:   A reference model of counts, extremes and records is kept here
`timescale 1ns/1ns
module testbench;
   logic                 core_clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 psel, penable, pwrite, pready_q, pslverr_q, err;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata_q, rdv;
   logic                 tkey = 1'b0, tport = 1'b0, cfg_chg = 1'b0;
   logic                 arng, cal_req_q, out_valid_q;
   mstm_pkg::mstm_samp_t mr = '0, mv = '0;
   mstm_pkg::mstm_pair_t out_data_q, od, eo;
   int                   error_cnt = 0, num_checks = 0, cal_n = 0, out_n = 0, eon = 0, n;
   int                   tot[2], val[2], mxn[2], mnn[2], tal[2][4];
   logic [31:0]          sum[2], mx[2], mn[2];
   logic [39:0]          recs[$];
   logic [5:0]           ctrl = 6'h00;

   mstm_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
      .pslverr_q(pslverr_q));
   mstm_top #(.CAL_CYCLES(38'd50)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .trig_key_pin(tkey), .external_control_port_trig(tport), .meas_res(mr),
      .meas_volt(mv), .cmp_cfg_change(cfg_chg), .auto_range_off_q(arng),
      .cal_req_q(cal_req_q), .out_valid_q(out_valid_q), .out_data_q(out_data_q));

   // Clock and watchdog; a hang counts as a mismatch
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      end_sim();
   end
   // Pulse counters; registered outputs seen as they stood before the edge
   always @(posedge core_clk) begin
      if (cal_req_q === 1'b1) cal_n++;
      if (out_valid_q === 1'b1) begin
         out_n++;
         od = out_data_q;
      end
   end

   task automatic end_sim();
      error_cnt += host.to_cnt;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rdv, err);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0000_0000, rdv, err);
      chk(nm, e, rdv);
   endtask
   task automatic cmd(input int k);
      wr(mstm_pkg::A_CMD, 32'h0000_0001 << k);
   endtask
   task automatic setc(input logic [5:0] v);
      ctrl = v;
      wr(mstm_pkg::A_CTRL, {26'h0, v});
   endtask
   function automatic logic [7:0] pa(input int q, input logic [5:0] o);
      return {(q != 0) ? mstm_pkg::PG_VOLT : mstm_pkg::PG_RES, o};
   endfunction
   function automatic logic [31:0] sx(input logic [19:0] v);
      return {{12{v[19]}}, v};
   endfunction
   function automatic mstm_pkg::mstm_samp_t rnd();
      rnd.value = 20'($urandom);
      rnd.fault = ($urandom % 6) == 0;
      rnd.ovf = ($urandom % 6) == 0;
      rnd.judge = mstm_pkg::mstm_judge_t'($urandom % 3);
   endfunction
   task automatic zero();
      for (int q = 0; q < 2; q++) begin
         tot[q] = 0;
         val[q] = 0;
         sum[q] = 32'h0000_0000;
         tal[q] = '{0, 0, 0, 0};
      end
   endtask
   // Reference model of one trigger; tally index follows judge, 3 is fault
   task automatic model();
      mstm_pkg::mstm_samp_t s;
      logic [31:0]          v;
      if (ctrl[1] && recs.size() < 400) recs.push_back({mr.value, mv.value});
      if (ctrl[4] && !ctrl[5]) begin
         eon++;
         eo = {mr.value, mv.value};
      end
      for (int q = 0; q < 2 && ctrl[0] && tot[q] < 30000; q++) begin
         s = (q != 0) ? mv : mr;
         v = sx(s.value);
         tot[q]++;
         if (s.fault) tal[q][3]++;
         else tal[q][s.judge]++;
         if (!s.fault && !s.ovf) begin
            val[q]++;
            sum[q] += v;
            if (val[q] == 1 || $signed(v) > $signed(mx[q])) begin
               mx[q] = v;
               mxn[q] = tot[q];
            end
            if (val[q] == 1 || $signed(v) < $signed(mn[q])) begin
               mn[q] = v;
               mnn[q] = tot[q];
            end
         end
      end
   endtask
   // Trigger from register (0), key pin (1) or control port pin (2)
   task automatic trig(input int src);
      @(posedge core_clk);
      mr <= rnd();
      mv <= rnd();
      if (src == 0) cmd(mstm_pkg::K_TRG);
      else begin
         @(posedge core_clk);
         if (src == 1) tkey <= 1'b1;
         else tport <= 1'b1;
         repeat (5) @(posedge core_clk);
         tkey <= 1'b0;
         tport <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      model();
   endtask
   task automatic chk_stats();
      for (int q = 0; q < 2; q++) begin
         rdc("cnt", pa(q, 6'h00), {1'b0, 15'(val[q]), 1'b0, 15'(tot[q])});
         rdc("sum", pa(q, 6'h04), sum[q]);
         if (val[q] > 0) begin
            rdc("max", pa(q, 6'h08), mx[q]);
            rdc("maxno", pa(q, 6'h0C), 32'(mxn[q]));
            rdc("min", pa(q, 6'h10), mn[q]);
            rdc("minno", pa(q, 6'h14), 32'(mnn[q]));
         end
         rdc("tal01", pa(q, 6'h18), {16'(tal[q][0]), 16'(tal[q][1])});
         rdc("tal23", pa(q, 6'h1C), {16'(tal[q][3]), 16'(tal[q][2])});
      end
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h8ed8_7e08));
      zero();
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      rdc("ctrl", mstm_pkg::A_CTRL, 32'h0000_0000);
      rdc("mcount", mstm_pkg::A_MCOUNT, 32'h0000_0000);
      rdc("sig", pa(0, 6'h20), 32'h0000_0000);
      rdc("unmapped", 8'hC0, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      setc(6'h03);
      // Override is registered one cycle after the control write
      repeat (2) @(posedge core_clk);
      chk("arange", 32'h0000_0001, {31'h0, arng});
      for (int i = 0; i < 24; i++) trig(i % 3);
      chk_stats();
      setc(6'h02);
      trig(1);
      setc(6'h03);
      chk_stats();
      rdc("mcount", mstm_pkg::A_MCOUNT, 32'(recs.size()));
      // Bulk download: each voltage read moves to the next record
      cmd(mstm_pkg::K_DL_START);
      foreach (recs[i]) begin
         rdc("idx", mstm_pkg::A_REC_IDX, 32'h8000_0000 | 32'(i + 1));
         rdc("rres", mstm_pkg::A_REC_RES, sx(recs[i][39:20]));
         rdc("rvolt", mstm_pkg::A_REC_VOLT, sx(recs[i][19:0]));
      end
      rdc("end", mstm_pkg::A_REC_IDX & 8'hFF, 32'h4000_0000);
      // Step download: reads do not advance, only the next request does
      setc(6'h07);
      cmd(mstm_pkg::K_DL_START);
      for (int i = 0; i < 3; i++) begin
         rdc("svolt", mstm_pkg::A_REC_VOLT, sx(recs[i][19:0]));
         rdc("sidx", mstm_pkg::A_REC_IDX, 32'h8000_0000 | 32'(i + 1));
         host.next_rec();
      end
      // Capability indices read clamped, both pages
      for (int q = 0; q < 2; q++) begin
         wr(pa(q, 6'h24), 32'hFFFB_2EE0);
         rdc("cp", pa(q, 6'h24), 32'h0000_270F);
         wr(pa(q, 6'h24), 32'h2710_FFFF);
         rdc("cp", pa(q, 6'h24), 32'h270F_0000);
      end
      setc(6'h03);
      cmd(mstm_pkg::K_STAT_CLR);
      zero();
      chk_stats();
      rdc("ctrl", mstm_pkg::A_CTRL, 32'h0000_0003);
      wr(pa(0, 6'h20), 32'h0000_1234);
      rdc("sig", pa(0, 6'h20), 32'h0000_0000);
      // Fill the record memory and push past it
      while (recs.size() < 400) trig(0);
      trig(2);
      rdc("mcount", mstm_pkg::A_MCOUNT, 32'h0000_0190);
      chk_stats();
      cmd(mstm_pkg::K_DL_START);
      rdc("first", mstm_pkg::A_REC_RES, sx(recs[0][39:20]));
      @(posedge core_clk);
      cfg_chg <= 1'b1;
      @(posedge core_clk);
      cfg_chg <= 1'b0;
      recs.delete();
      rdc("mcount", mstm_pkg::A_MCOUNT, 32'h0000_0000);
      // Automatic output, then suppressed with the GP-IB port active
      setc(6'h11);
      trig(1);
      setc(6'h31);
      trig(0);
      chk("outn", 32'(eon), 32'(out_n));
      chk("outr", sx(eo.res), sx(od.res));
      chk("outv", sx(eo.volt), sx(od.volt));
      // Periodic calibration every 50 cycles, then one on command
      setc(6'h08);
      repeat (500) @(posedge core_clk);
      setc(6'h00);
      // Let a periodic pulse launched at the disabling edge be counted first
      repeat (2) @(posedge core_clk);
      chk("caln", 32'h0000_0001, 32'(cal_n >= 9 && cal_n <= 11));
      n = cal_n;
      cmd(mstm_pkg::K_CAL);
      repeat (3) @(posedge core_clk);
      chk("calcmd", 32'(n + 1), 32'(cal_n));
      end_sim();
   end
endmodule // testbench
